// file: src/ssf_status_flags.sv
// Serial port status and control flags with APB slave and interrupt
//
// Contract
// - I2C stop seen last sets stop flag
// - I2C start seen last sets start flag
// - Capture direction bit of matching address byte
// - Direction valid until start, stop or acknowledge
// - Buffer full on completed receive, else empty
// - Buffer full while I2C transmit in progress
// - Data/address flag follows last byte kind
`timescale 1ns/100ps
`default_nettype none
module ssf_status_flags (
    input wire logic clock,                 // Core clock, 100 MHz
    input wire logic srst,                  // Sync reset, high
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic pwrite,                // APB direction
    input wire logic [7:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,         // APB write data
    output logic [31:0] prdata,             // APB read data
    output logic pready,                    // APB ready
    output logic pslverr,                   // APB error, unmapped
    input wire ssf_pkg::ssf_evt_t evt,      // Shift engine events
    output ssf_pkg::ssf_ctl_t ctl,          // Shift engine controls
    output logic irq                        // Level interrupt
);

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : addr_hit

    // Codes with mode bit 3 set or bits 2:1 both set select I2C
    function automatic logic is_i2c_mode(input logic [3:0] m);
        return m[3] | (m[2] & m[1]);
    endfunction : is_i2c_mode

    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [6:0] ctrl_r;
    logic write_collision_flag_r;
    logic start_r;
    logic stop_r;
    logic rw_r;
    logic da_r;
    logic bf_r;
    logic [7:0] rx_buf_r;
    logic [7:0] tx_byte_r;
    logic tx_load_r;
    logic [31:0] prdata_r;
    logic slverr_r;
    logic enable;
    logic i2c;
    logic buf_wr;
    logic buf_rd;
    logic ctrl_wr;
    logic write_collision_flag_set;
    logic write_collision_flag_clr;
    logic tx_accept;
    logic dir_end;
    logic [7:0] ctrl_byte;
    logic [7:0] stat_byte;
    logic [ssf_pkg::IRQ_W-1:0] irq_set;
    logic [ssf_pkg::IRQ_W-1:0] irq_status;
    logic [ssf_pkg::IRQ_W-1:0] irq_mask;

    // APB phases; zero wait states, so access always completes
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite;
    assign rd_acc = access & ~pwrite;
    assign pready = 1'b1;

    assign mapped = addr_hit(paddr, ssf_pkg::CTRL_OFFSET)
                  | addr_hit(paddr, ssf_pkg::STAT_OFFSET)
                  | addr_hit(paddr, ssf_pkg::BUF_OFFSET)
                  | addr_hit(paddr, ssf_pkg::IRQ_STAT_OFFSET)
                  | addr_hit(paddr, ssf_pkg::IRQ_MASK_OFFSET);

    assign ctrl_wr = wr_acc & addr_hit(paddr, ssf_pkg::CTRL_OFFSET);
    assign buf_wr = wr_acc & addr_hit(paddr, ssf_pkg::BUF_OFFSET);
    assign buf_rd = rd_acc & addr_hit(paddr, ssf_pkg::BUF_OFFSET);

    assign enable = ctrl_r[ssf_pkg::CTRL_EN_BIT];
    assign i2c = enable & is_i2c_mode(ctrl_r[ssf_pkg::CTRL_MODE_W-1:0]);

    // Busy write is dropped, not queued, so the engine never sees it
    assign write_collision_flag_set = buf_wr & evt.shift_busy;
    assign write_collision_flag_clr = ctrl_wr & ~pwdata[ssf_pkg::CTRL_WRITE_COLLISION_FLAG_BIT];
    assign tx_accept = buf_wr & ~evt.shift_busy & enable;
    assign dir_end = evt.cond_start | evt.cond_stop | evt.ack_seen;

    // Control bits below the collision flag
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_r <= ssf_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= pwdata[6:0];
        end
    end

    // Collision flag: hardware only sets, set wins over software clear
    always_ff @(posedge clock) begin
        if (srst) begin
            write_collision_flag_r <= 1'b0;
        end else if (write_collision_flag_set) begin
            write_collision_flag_r <= 1'b1;
        end else if (write_collision_flag_clr) begin
            write_collision_flag_r <= 1'b0;
        end
    end

    // Last bus condition; disabling the port forgets both
    always_ff @(posedge clock) begin
        if (srst || !enable) begin
            start_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (i2c && evt.cond_stop) begin
            stop_r <= 1'b1;
            start_r <= 1'b0;
        end else if (i2c && evt.cond_start) begin
            start_r <= 1'b1;
            stop_r <= 1'b0;
        end
    end

    // Direction of the last match, dropped at the next boundary
    always_ff @(posedge clock) begin
        if (srst) begin
            rw_r <= 1'b0;
        end else if (i2c && evt.addr_match) begin
            rw_r <= evt.addr_rw;
        end else if (dir_end) begin
            rw_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            da_r <= 1'b0;
        end else if (i2c && evt.byte_done) begin
            da_r <= evt.byte_is_data;
        end
    end

    // Full on receive or on an accepted I2C load; set wins over clear
    always_ff @(posedge clock) begin
        if (srst) begin
            bf_r <= 1'b0;
        end else if (evt.rx_done || (tx_accept && i2c)) begin
            bf_r <= 1'b1;
        end else if (buf_rd || (i2c && evt.tx_done)) begin
            bf_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_buf_r <= ssf_pkg::BUF_RESET;
        end else if (evt.rx_done) begin
            rx_buf_r <= evt.rx_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_byte_r <= ssf_pkg::BUF_RESET;
            tx_load_r <= 1'b0;
        end else begin
            tx_load_r <= tx_accept;
            if (tx_accept) begin
                tx_byte_r <= pwdata[7:0];
            end
        end
    end

    assign ctrl_byte = {write_collision_flag_r, ctrl_r};
    assign stat_byte = {2'b00, da_r, stop_r, start_r, rw_r, 1'b0, bf_r};

    // Read data is latched in the setup phase and stands in access
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_r <= ssf_pkg::RDATA_RESET;
            slverr_r <= 1'b0;
        end else if (setup) begin
            slverr_r <= ~mapped;
            if (pwrite || !mapped) begin
                prdata_r <= ssf_pkg::RDATA_RESET;
            end else if (addr_hit(paddr, ssf_pkg::CTRL_OFFSET)) begin
                prdata_r <= {24'h000000, ctrl_byte};
            end else if (addr_hit(paddr, ssf_pkg::STAT_OFFSET)) begin
                prdata_r <= {24'h000000, stat_byte};
            end else if (addr_hit(paddr, ssf_pkg::BUF_OFFSET)) begin
                prdata_r <= {24'h000000, rx_buf_r};
            end else if (addr_hit(paddr, ssf_pkg::IRQ_STAT_OFFSET)) begin
                prdata_r <= {28'h0000000, irq_status};
            end else begin
                prdata_r <= {28'h0000000, irq_mask};
            end
        end
    end

    assign prdata = prdata_r;
    assign pslverr = slverr_r & access;

    assign irq_set[ssf_pkg::IRQ_START_BIT] = i2c & evt.cond_start;
    assign irq_set[ssf_pkg::IRQ_STOP_BIT] = i2c & evt.cond_stop;
    assign irq_set[ssf_pkg::IRQ_RX_BIT] = evt.rx_done;
    assign irq_set[ssf_pkg::IRQ_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_set;

    ssf_irq_sticky u_irq (
        .clock(clock),
        .srst(srst),
        .set_evt(irq_set),
        .clr_wr(wr_acc & addr_hit(paddr, ssf_pkg::IRQ_STAT_OFFSET)),
        .mask_wr(wr_acc & addr_hit(paddr, ssf_pkg::IRQ_MASK_OFFSET)),
        .wdata(pwdata[ssf_pkg::IRQ_W-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    assign ctl.port_enable_bit = ctrl_r[ssf_pkg::CTRL_EN_BIT];
    assign ctl.clock_polarity_select = ctrl_r[ssf_pkg::CTRL_CKP_BIT];
    assign ctl.port_mode_select = ctrl_r[ssf_pkg::CTRL_MODE_W-1:0];
    assign ctl.tx_load = tx_load_r;
    assign ctl.tx_byte = tx_byte_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_match;
        i2c && evt.addr_match && evt.addr_rw;
    endsequence

    sequence s_quiet;
        !dir_end && !evt.addr_match;
    endsequence

    a_stop_last: assert property (i2c && evt.cond_stop |=> stop_r && !start_r)
        else $error("stop flag not set after stop");

    a_start_last: assert property (
        i2c && evt.cond_start && !evt.cond_stop |=> start_r && !stop_r)
        else $error("start flag not set after start");

    a_disable_clr: assert property (!enable |=> !start_r && !stop_r)
        else $error("bus condition flags survive disable");

    a_dir_capture: assert property (
        i2c && evt.addr_match |=> rw_r == $past(evt.addr_rw))
        else $error("direction not captured at match");

    a_dir_held: assert property (s_match ##1 s_quiet |=> rw_r)
        else $error("direction lost before boundary");

    a_dir_expire: assert property (
        dir_end && !(i2c && evt.addr_match) |=> !rw_r)
        else $error("direction kept past boundary");

    a_bf_rx: assert property (evt.rx_done |=> bf_r ##0 stat_byte[0])
        else $error("buffer full not set on receive");

    a_bf_hold: assert property (
        bf_r && !buf_rd && !(i2c && evt.tx_done) |=> bf_r)
        else $error("buffer full dropped early");

    a_bf_tx_done: assert property (
        i2c && evt.tx_done && !evt.rx_done && !tx_accept |=> !bf_r)
        else $error("buffer full not cleared after transmit");

    a_write_collision_flag_set: assert property (
        buf_wr && evt.shift_busy |=> write_collision_flag_r && !tx_load_r)
        else $error("collision not flagged or write leaked");

    a_write_collision_flag_keep: assert property (write_collision_flag_r && !write_collision_flag_clr |=> write_collision_flag_r)
        else $error("collision flag cleared by hardware");

    a_da_kind: assert property (
        i2c && evt.byte_done |=> da_r == $past(evt.byte_is_data))
        else $error("data/address flag wrong");

    a_da_keep: assert property (
        !(i2c && evt.byte_done) |=> $stable(da_r))
        else $error("data/address flag changed without a byte");

    a_cond_keep: assert property (
        enable && !evt.cond_start && !evt.cond_stop |=> $stable(start_r) && $stable(stop_r))
        else $error("bus condition flags changed without a condition");

    a_bf_load: assert property (
        tx_accept && i2c |=> bf_r)
        else $error("buffer full not set on accepted load");

    // A clean write must reach the engine, or the collision check is moot
    a_load_pass: assert property (
        tx_accept |=> tx_load_r && ctl.tx_byte == $past(pwdata[7:0]))
        else $error("accepted buffer write not passed to engine");

endmodule : ssf_status_flags
`default_nettype wire

// file: shared/ssf_pkg.sv
// Package: register map, field positions, reset values and carrier types
`default_nettype none
package ssf_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] CTRL_OFFSET = 8'h14;
    localparam logic [7:0] STAT_OFFSET = 8'h18;
    localparam logic [7:0] BUF_OFFSET = 8'h1c;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h24;

    // Control register fields
    localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int CTRL_OVF_BIT = 6;
    localparam int CTRL_EN_BIT = 5;
    localparam int CTRL_CKP_BIT = 4;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 4;

    // Status register fields
    localparam int STAT_DA_BIT = 5;
    localparam int STAT_STOP_BIT = 4;
    localparam int STAT_START_BIT = 3;
    localparam int STAT_RW_BIT = 2;
    localparam int STAT_UA_BIT = 1;
    localparam int STAT_BF_BIT = 0;

    // Interrupt status and mask fields
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;
    localparam int IRQ_RX_BIT = 2;
    localparam int IRQ_WRITE_COLLISION_FLAG_BIT = 3;
    localparam int IRQ_W = 4;

    // Values after reset
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Events from the shift engine, one-cycle pulses except noted levels
    typedef struct packed {
        logic cond_start;
        logic cond_stop;
        logic addr_match;
        logic addr_rw;          // Level, valid with addr_match
        logic ack_seen;
        logic byte_done;
        logic byte_is_data;     // Level, valid with byte_done
        logic rx_done;
        logic [7:0] rx_byte;    // Valid with rx_done
        logic tx_done;
        logic shift_busy;       // Level
    } ssf_evt_t;

    // Controls toward the shift engine
    typedef struct packed {
        logic port_enable_bit;
        logic clock_polarity_select;
        logic [3:0] port_mode_select;
        logic tx_load;          // One-cycle pulse
        logic [7:0] tx_byte;
    } ssf_ctl_t;

endpackage : ssf_pkg
`default_nettype wire

// file: src/ssf_irq_sticky.sv
// Sticky write-one-to-clear interrupt status with mask and level output
`timescale 1ns/100ps
`default_nettype none
module ssf_irq_sticky (
    input wire logic clock,                               // Core clock
    input wire logic srst,                                // Sync reset, high
    input wire logic [ssf_pkg::IRQ_W-1:0] set_evt,        // Event pulses
    input wire logic clr_wr,                              // Status write pulse
    input wire logic mask_wr,                             // Mask write pulse
    input wire logic [ssf_pkg::IRQ_W-1:0] wdata,          // Write data
    output logic [ssf_pkg::IRQ_W-1:0] status,             // Sticky status
    output logic [ssf_pkg::IRQ_W-1:0] mask,               // Enable mask
    output logic irq                                      // Level interrupt
);

    logic [ssf_pkg::IRQ_W-1:0] status_r;
    logic [ssf_pkg::IRQ_W-1:0] mask_r;
    logic [ssf_pkg::IRQ_W-1:0] clr_bits;

    assign clr_bits = clr_wr ? wdata : ssf_pkg::IRQ_RESET;

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock) begin
        if (srst) begin
            status_r <= ssf_pkg::IRQ_RESET;
        end else begin
            status_r <= (status_r & ~clr_bits) | set_evt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mask_r <= ssf_pkg::IRQ_RESET;
        end else if (mask_wr) begin
            mask_r <= wdata;
        end
    end

    assign status = status_r;
    assign mask = mask_r;
    assign irq = |(status_r & mask_r);

    a_irq_set_wins: assert property (@(posedge clock) disable iff (srst)
        set_evt[0] |=> status[0] ##0 (irq == mask[0] || status[3:1] != 3'h0))
        else $error("interrupt event lost");

    a_irq_sticky: assert property (@(posedge clock) disable iff (srst)
        (status[1] && !(clr_wr && wdata[1])) |=> status[1])
        else $error("sticky bit dropped without clear");

endmodule : ssf_irq_sticky
`default_nettype wire

// file: sim/ssf_engine_model.sv
// Shift engine stand-in: event pulses on request, busy after each load
`timescale 1ns/100ps
`default_nettype none
module ssf_engine_model #(
    parameter int BUSY_CYC = 20 // Shift time of one word
) (
    input wire logic clock, // Core clock
    input wire logic srst, // Sync reset, high
    input wire ssf_pkg::ssf_ctl_t ctl, // Controls from the block
    output ssf_pkg::ssf_evt_t evt // Events to the block
);
    ssf_pkg::ssf_evt_t pulse_r = '0;
    logic busy_r;
    logic done_r;
    int cnt_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 0;
        end else begin
            done_r <= busy_r && cnt_r == 1;
            if (ctl.tx_load) begin
                busy_r <= 1'b1;
                cnt_r <= BUSY_CYC;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
                busy_r <= cnt_r > 1;
            end
        end
    end

    always_comb begin
        evt = pulse_r;
        evt.shift_busy = busy_r;
        evt.tx_done = done_r;
    end

    // Stale levels are inverted so the block cannot lean on them
    task automatic fire(input ssf_pkg::ssf_evt_t e);
        ssf_pkg::ssf_evt_t idle;
        idle = '0;
        idle.addr_rw = ~e.addr_rw;
        idle.byte_is_data = ~e.byte_is_data;
        idle.rx_byte = ~e.rx_byte;
        @(posedge clock);
        pulse_r <= e;
        @(posedge clock);
        pulse_r <= idle;
    endtask : fire
endmodule : ssf_engine_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the serial port status flags
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [7:0] A_CTRL = ssf_pkg::CTRL_OFFSET;
    localparam logic [7:0] A_STAT = ssf_pkg::STAT_OFFSET;
    localparam logic [7:0] A_BUF = ssf_pkg::BUF_OFFSET;
    localparam logic [7:0] A_IST = ssf_pkg::IRQ_STAT_OFFSET;
    localparam logic [7:0] A_IMSK = ssf_pkg::IRQ_MASK_OFFSET;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    ssf_pkg::ssf_evt_t evt;
    ssf_pkg::ssf_ctl_t ctl;
    int num_errors = 0;
    int comparisons = 0;
    int n_load = 0;
    logic [31:0] seed = 32'h497a;
    logic [31:0] rd;
    logic err;
    logic i2c_on = 1'b0;
    logic e_da = 1'b0, e_p = 1'b0, e_s = 1'b0, e_rw = 1'b0, e_bf = 1'b0;

    always #5 clock = ~clock;
    always @(posedge clock) begin
        if (ctl.tx_load === 1'b1) n_load++;
    end

    ssf_status_flags i_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .ctl(ctl), .irq(irq));
    ssf_engine_model #(.BUSY_CYC(20)) i_eng (.clock(clock), .srst(srst), .ctl(ctl), .evt(evt));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [31:0] exp_status();
        return {26'h0, e_da, e_p, e_s, e_rw, 1'b0, e_bf};
    endfunction : exp_status

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog ends a stalled access
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    // Kinds: 0 start, 1 stop, 2 match, 3 ack, 4 byte, 5 receive, 6 start and stop
    task automatic send(input int k, input logic v, input logic [7:0] b);
        ssf_pkg::ssf_evt_t e;
        e = '0;
        e.cond_start = k == 0 || k == 6;
        e.cond_stop = k == 1 || k == 6;
        e.addr_match = k == 2;
        e.addr_rw = v;
        e.ack_seen = k == 3;
        e.byte_done = k == 4;
        e.byte_is_data = v;
        e.rx_done = k == 5;
        e.rx_byte = b;
        i_eng.fire(e);
        if (i2c_on) begin
            if (k == 0) {e_s, e_p} = 2'b10;
            if (k == 1 || k == 6) {e_s, e_p} = 2'b01;
            if (k == 2) e_rw = v;
            else if (k != 4 && k != 5) e_rw = 1'b0;
            if (k == 4) e_da = v;
        end
        if (k == 5) e_bf = 1'b1;
        rd_chk(A_STAT, exp_status());
    endtask : send

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        print_verdict();
    end

    initial begin
        int k;
        logic [7:0] b;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(A_CTRL + 8'(4 * i), 32'h0);
        apb(1'b1, 8'h40, 32'hff);
        check({31'h0, err}, 32'h1);
        rd_chk(8'h40, 32'h0);
        // Receive counts in any mode, conditions only under I2C
        apb(1'b1, A_CTRL, 32'h20);
        send(0, 1'b0, 8'h00);
        send(1, 1'b0, 8'h00);
        send(5, 1'b0, 8'h5a);
        rd_chk(A_BUF, 32'h5a);
        e_bf = 1'b0;
        apb(1'b1, A_CTRL, 32'h2e);
        i2c_on = 1'b1;
        #1 check({27'h0, ctl.port_enable_bit, ctl.port_mode_select}, 32'h1e);
        send(6, 1'b0, 8'h00);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            k = int'(seed[2:0]) % 7;
            b = seed[23:16];
            send(k, seed[8], b);
            if (k == 5) begin
                rd_chk(A_BUF, {24'h0, b});
                e_bf = 1'b0;
            end
        end
        // Masked and unmasked interrupt sources
        apb(1'b1, A_IST, 32'hf);
        apb(1'b1, A_IMSK, 32'h1);
        send(0, 1'b0, 8'h00);
        #1 check({31'h0, irq}, 32'h1);
        apb(1'b1, A_IST, 32'h1);
        #1 check({31'h0, irq}, 32'h0);
        send(1, 1'b0, 8'h00);
        #1 check({31'h0, irq}, 32'h0);
        rd_chk(A_IST, 32'h2);
        apb(1'b1, A_IST, 32'h2);
        // Second write lands while the first word still shifts
        b = seed[7:0];
        apb(1'b1, A_BUF, {24'h0, b});
        apb(1'b1, A_BUF, {24'h0, ~b});
        check({24'h0, ctl.tx_byte}, {24'h0, b});
        check(32'(n_load), 32'h1);
        e_bf = 1'b1;
        rd_chk(A_STAT, exp_status());
        rd_chk(A_CTRL, 32'hae);
        rd_chk(A_IST, 32'h8);
        apb(1'b1, A_CTRL, 32'h2e);
        rd_chk(A_CTRL, 32'h2e);
        k = 0;
        while (evt.shift_busy === 1'b1 && k < 100) begin
            @(posedge clock);
            k++;
        end
        e_bf = 1'b0;
        rd_chk(A_STAT, exp_status());
        // Mode code 6 decodes as I2C too; disabling drops the condition flags
        apb(1'b1, A_CTRL, 32'h26);
        send(0, 1'b0, 8'h00);
        apb(1'b1, A_CTRL, 32'h0e);
        {e_s, e_p} = 2'b00;
        rd_chk(A_STAT, exp_status());
        // Polarity and overflow are stored; writing a one never sets collision
        apb(1'b1, A_CTRL, 32'hde);
        #1 check({31'h0, ctl.clock_polarity_select}, 32'h1);
        rd_chk(A_CTRL, 32'h5e);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
